// [rtl/mapc_pkg.sv]
/*
  Shared constants and types of the maximum-address limit controller: register map,
  command codes, field positions, identify bits and state encodings.
  Assumes a 32-bit APB register bus and 48-bit logical block addresses.
*/
package mapc_pkg;

  localparam int unsigned LBA_W = 48;
  localparam int unsigned PW_W = 32;
  localparam int unsigned ADDR_W = 12;

  // native highest block of the medium, fixed for this drive
  localparam logic [47:0] NATIVE_MAX_LBA = 48'h0000_00C1_ACFF;

  localparam logic [7:0] OP_READ_NATIVE = 8'hF8;
  localparam logic [7:0] OP_SET_MAX = 8'hF9;

  localparam logic [7:0] SUB_SET_MAX = 8'h00;
  localparam logic [7:0] SUB_SET_PW = 8'h01;
  localparam logic [7:0] SUB_LOCK = 8'h02;
  localparam logic [7:0] SUB_UNLOCK = 8'h03;
  localparam logic [7:0] SUB_FREEZE = 8'h04;

  localparam logic [11:0] OFF_CMD = 12'h000;
  localparam logic [11:0] OFF_ARG_LO = 12'h004;
  localparam logic [11:0] OFF_ARG_HI = 12'h008;
  localparam logic [11:0] OFF_PWD = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_RES_LO = 12'h014;
  localparam logic [11:0] OFF_RES_HI = 12'h018;
  localparam logic [11:0] OFF_MAX_LO = 12'h01C;
  localparam logic [11:0] OFF_MAX_HI = 12'h020;
  localparam logic [11:0] OFF_IDENT = 12'h024;
  localparam logic [11:0] OFF_ID_CAP = 12'h028;

  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_FEAT_LSB = 8;
  localparam int unsigned CMD_NV_BIT = 16;

  // identify word 83 / 86 bit for the set-max security extension
  localparam int unsigned ID_SETMAX_BIT = 8;

  localparam logic [1:0] PU_SYNC_CYCLES = 2'h2;

  localparam logic [47:0] LBA_ZERO = 48'h0000_0000_0000;
  localparam logic [31:0] PW_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    LK_UNLOCKED = 2'b00,
    LK_LOCKED = 2'b01,
    LK_FROZEN = 2'b10
  } mapc_lock_e;

  typedef enum logic [1:0] {
    PU_SYNC = 2'b00,
    PU_LOAD = 2'b01,
    PU_RUN = 2'b10
  } mapc_pu_e;

  typedef struct packed {
    logic nv;
    logic [7:0] feat;
    logic [7:0] opcode;
  } mapc_cmd_s;

  typedef struct packed {
    logic acc_deny;
    logic pw_set;
    mapc_lock_e lock;
    logic abort;
    logic done;
  } mapc_stat_s;

  localparam mapc_cmd_s CMD_RESET = 17'h0_0000;

endpackage

// [rtl/mapc_sync.sv]
/*
  Two-flop synchroniser for levels arriving from outside the pclk domain.
  Assumes multi-bit inputs are quasi-static while they are sampled.
*/
`timescale 1ns/1ps
module mapc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// [rtl/mapc_lba_limit.sv]
/*
  Access gate: checks each media request against the current maximum block.
  Assumes requests come from logic on pclk, one per cycle at most.
*/
`timescale 1ns/1ps
module mapc_lba_limit
  import mapc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic acc_valid,
  input wire logic [LBA_W-1:0] acc_lba,
  input wire logic [LBA_W-1:0] max_lba,
  output logic acc_done,
  output logic acc_deny
);

  logic acc_done_d;
  logic acc_deny_d;

  always_comb begin
    acc_done_d = acc_valid;
    // anything past the limit looks like a block that does not exist
    acc_deny_d = acc_valid && (acc_lba > max_lba);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_done <= 1'b0;
      acc_deny <= 1'b0;
    end else begin
      acc_done <= acc_done_d;
      acc_deny <= acc_deny_d;
    end
  end

endmodule

// [rtl/mapc_ctrl.sv]
/*
  Maximum-address limit controller: command interpreter for read-native-max and
  set-max with its password, lock, unlock and freeze-lock extension, APB registers,
  identify reporting and the media access gate.
  Assumes presetn is the power-on reset, drive_reset a hard/soft reset level from the
  link side, and nv_max_lba the stored nonvolatile limit, stable around power-up.
*/
`timescale 1ns/1ps
module mapc_ctrl
  import mapc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic drive_reset,
  input wire logic [LBA_W-1:0] nv_max_lba,
  output logic nv_wr,
  output logic [LBA_W-1:0] nv_wr_lba,
  output logic [LBA_W-1:0] max_lba,
  input wire logic acc_valid,
  input wire logic [LBA_W-1:0] acc_lba,
  output logic acc_done,
  output logic acc_deny
);

  // bus side
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic wr_en;
  logic setup;

  // argument and command registers
  mapc_cmd_s cmd_q, cmd_d;
  logic [LBA_W-1:0] arg_q, arg_d;
  logic [PW_W-1:0] pwd_arg_q, pwd_arg_d;
  logic [LBA_W-1:0] res_q, res_d;

  // limit and extension state
  logic [LBA_W-1:0] max_q, max_d;
  logic [LBA_W-1:0] nv_shadow_q, nv_shadow_d;
  logic [PW_W-1:0] pw_q, pw_d;
  logic pw_set_q, pw_set_d;
  mapc_lock_e lock_q, lock_d;
  logic done_q, done_d;
  logic abort_q, abort_d;
  logic nv_wr_q, nv_wr_d;
  logic [LBA_W-1:0] nv_wr_lba_q, nv_wr_lba_d;

  // power-up and reset tracking
  mapc_pu_e pu_q, pu_d;
  logic [1:0] pu_cnt_q, pu_cnt_d;
  logic hrst_s;
  logic hrst_prev_q;
  logic hrst_evt;
  logic [LBA_W-1:0] nv_in_s;
  logic [LBA_W-1:0] nv_in_clip;

  mapc_cmd_s cmd_in;
  logic cmd_go;
  logic abort_c;
  mapc_stat_s stat;
  logic [15:0] id_w83;
  logic [15:0] id_w86;
  logic [LBA_W-1:0] cap;

  mapc_sync #(.W(1)) u_sync_rst (
    .pclk(pclk),
    .presetn(presetn),
    .d(drive_reset),
    .q(hrst_s)
  );

  mapc_sync #(.W(LBA_W)) u_sync_nv (
    .pclk(pclk),
    .presetn(presetn),
    .d(nv_max_lba),
    .q(nv_in_s)
  );

  mapc_lba_limit u_limit (
    .pclk(pclk),
    .presetn(presetn),
    .acc_valid(acc_valid),
    .acc_lba(acc_lba),
    .max_lba(max_q),
    .acc_done(acc_done),
    .acc_deny(acc_deny)
  );

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready_q;
  assign hrst_evt = hrst_s && !hrst_prev_q;
  assign cmd_in = '{nv: pwdata[CMD_NV_BIT], feat: pwdata[CMD_FEAT_LSB +: 8], opcode: pwdata[CMD_OP_LSB +: 8]};
  assign cmd_go = wr_en && (paddr == OFF_CMD);
  assign nv_in_clip = (nv_in_s > NATIVE_MAX_LBA) ? NATIVE_MAX_LBA : nv_in_s;
  assign cap = max_q + 48'h0000_0000_0001;
  assign stat = '{acc_deny: acc_deny, pw_set: pw_set_q, lock: lock_q, abort: abort_q, done: done_q};

  always_comb begin
    id_w83 = 16'h0000;
    id_w86 = 16'h0000;
    id_w83[ID_SETMAX_BIT] = 1'b1;
    id_w86[ID_SETMAX_BIT] = pw_set_q;
  end

  // bus answer: one wait-free access phase, registered data and error
  always_comb begin
    pready_d = setup;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        OFF_CMD: prdata_d = {15'h0000, cmd_q};
        OFF_ARG_LO: prdata_d = arg_q[31:0];
        OFF_ARG_HI: prdata_d = {16'h0000, arg_q[47:32]};
        OFF_PWD: prdata_d = 32'h0000_0000;
        OFF_STATUS: prdata_d = {26'h000_0000, stat};
        OFF_RES_LO: prdata_d = res_q[31:0];
        OFF_RES_HI: prdata_d = {16'h0000, res_q[47:32]};
        OFF_MAX_LO: prdata_d = max_q[31:0];
        OFF_MAX_HI: prdata_d = {16'h0000, max_q[47:32]};
        OFF_IDENT: prdata_d = {id_w86, id_w83};
        OFF_ID_CAP: prdata_d = cap[31:0];
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  // argument registers
  always_comb begin
    arg_d = arg_q;
    pwd_arg_d = pwd_arg_q;
    if (wr_en && paddr == OFF_ARG_LO) begin
      arg_d[31:0] = pwdata;
    end
    if (wr_en && paddr == OFF_ARG_HI) begin
      arg_d[47:32] = pwdata[15:0];
    end
    if (wr_en && paddr == OFF_PWD) begin
      pwd_arg_d = pwdata;
    end
  end

  // command interpreter
  always_comb begin
    cmd_d = cmd_q;
    res_d = res_q;
    max_d = max_q;
    nv_shadow_d = nv_shadow_q;
    pw_d = pw_q;
    pw_set_d = pw_set_q;
    lock_d = lock_q;
    done_d = done_q;
    abort_d = abort_q;
    nv_wr_d = 1'b0;
    nv_wr_lba_d = nv_wr_lba_q;
    abort_c = 1'b0;
    if (cmd_go) begin
      cmd_d = cmd_in;
      if (pu_q != PU_RUN) begin
        abort_c = 1'b1;
      end else begin
        case (cmd_in.opcode)
          OP_READ_NATIVE: begin
            res_d = NATIVE_MAX_LBA;
          end
          OP_SET_MAX: begin
            case (cmd_in.feat)
              SUB_SET_MAX: begin
                if (lock_q != LK_UNLOCKED || arg_q > NATIVE_MAX_LBA) begin
                  abort_c = 1'b1;
                end else begin
                  max_d = arg_q;
                  res_d = arg_q;
                  if (cmd_in.nv) begin
                    nv_shadow_d = arg_q;
                    nv_wr_d = 1'b1;
                    nv_wr_lba_d = arg_q;
                  end
                end
              end
              SUB_SET_PW: begin
                if (lock_q != LK_UNLOCKED) begin
                  abort_c = 1'b1;
                end else begin
                  pw_d = pwd_arg_q;
                  pw_set_d = 1'b1;
                  lock_d = LK_UNLOCKED;
                end
              end
              SUB_LOCK: begin
                if (lock_q != LK_UNLOCKED || !pw_set_q) begin
                  abort_c = 1'b1;
                end else begin
                  lock_d = LK_LOCKED;
                end
              end
              SUB_UNLOCK: begin
                if (lock_q != LK_LOCKED || pwd_arg_q != pw_q) begin
                  abort_c = 1'b1;
                end else begin
                  lock_d = LK_UNLOCKED;
                end
              end
              SUB_FREEZE: begin
                if (lock_q != LK_UNLOCKED) begin
                  abort_c = 1'b1;
                end else begin
                  lock_d = LK_FROZEN;
                end
              end
              default: abort_c = 1'b1;
            endcase
          end
          default: abort_c = 1'b1;
        endcase
      end
      done_d = 1'b1;
      abort_d = abort_c;
    end
    // stored limit back in force after hard/soft reset; password and lock kept
    if (hrst_evt) begin
      max_d = nv_shadow_q;
    end
    if (pu_q == PU_LOAD) begin
      max_d = nv_in_clip;
      nv_shadow_d = nv_in_clip;
    end
  end

  // power-up sequence: let the stored limit settle through the synchroniser
  always_comb begin
    pu_d = pu_q;
    pu_cnt_d = pu_cnt_q;
    case (pu_q)
      PU_SYNC: begin
        pu_cnt_d = pu_cnt_q + 2'h1;
        if (pu_cnt_q == PU_SYNC_CYCLES) begin
          pu_d = PU_LOAD;
        end
      end
      PU_LOAD: pu_d = PU_RUN;
      PU_RUN: pu_d = PU_RUN;
      default: pu_d = PU_SYNC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      arg_q <= LBA_ZERO;
      pwd_arg_q <= PW_ZERO;
      hrst_prev_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      arg_q <= arg_d;
      pwd_arg_q <= pwd_arg_d;
      hrst_prev_q <= hrst_s;
    end
  end

  // power-on clears password and lock; volatile limit falls with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= CMD_RESET;
      res_q <= LBA_ZERO;
      max_q <= NATIVE_MAX_LBA;
      nv_shadow_q <= NATIVE_MAX_LBA;
      pw_q <= PW_ZERO;
      pw_set_q <= 1'b0;
      lock_q <= LK_UNLOCKED;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      nv_wr_q <= 1'b0;
      nv_wr_lba_q <= LBA_ZERO;
    end else begin
      cmd_q <= cmd_d;
      res_q <= res_d;
      max_q <= max_d;
      nv_shadow_q <= nv_shadow_d;
      pw_q <= pw_d;
      pw_set_q <= pw_set_d;
      lock_q <= lock_d;
      done_q <= done_d;
      abort_q <= abort_d;
      nv_wr_q <= nv_wr_d;
      nv_wr_lba_q <= nv_wr_lba_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_q <= PU_SYNC;
      pu_cnt_q <= 2'h0;
    end else begin
      pu_q <= pu_d;
      pu_cnt_q <= pu_cnt_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign nv_wr = nv_wr_q;
  assign nv_wr_lba = nv_wr_lba_q;
  assign max_lba = max_q;

endmodule

// [tb/mapc_nv_store.sv]
/*
  Nonvolatile limit store model beside the controller.
  Assumes nv_wr pulses on pclk; keeps its value through every reset.
*/
`timescale 1ns/1ps
module mapc_nv_store
  import mapc_pkg::*;
#(
  parameter logic [47:0] INIT = 48'h0000_00C1_ACFF
) (
  input wire logic pclk,
  input wire logic nv_wr,
  input wire logic [LBA_W-1:0] nv_wr_lba,
  output logic [LBA_W-1:0] nv_max_lba
);
  initial nv_max_lba = INIT;
  always @(posedge pclk) begin
    if (nv_wr) begin
      nv_max_lba <= nv_wr_lba;
    end
  end
endmodule

// [tb/mapc_chk.sv]
/*
  Port checker of mapc_ctrl.
  Assumes it is bound to every mapc_ctrl instance.
*/
`timescale 1ns/1ps
module mapc_chk
  import mapc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic nv_wr,
  input wire logic [LBA_W-1:0] nv_wr_lba,
  input wire logic [LBA_W-1:0] max_lba,
  input wire logic acc_valid,
  input wire logic [LBA_W-1:0] acc_lba,
  input wire logic acc_done,
  input wire logic acc_deny
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic rd, cw;
  assign rd = psel && penable && pready && !pwrite;
  assign cw = psel && penable && pready && pwrite && paddr == OFF_CMD;
  property p_gate;
    acc_valid |=> acc_done && acc_deny == ($past(acc_lba) > $past(max_lba));
  endproperty
  a_gate: assert property (p_gate) else $error("gate verdict wrong");
  property p_quiet;
    !acc_valid |=> !acc_done;
  endproperty
  a_quiet: assert property (p_quiet) else $error("gate answer without request");
  property p_nvpulse;
    nv_wr |=> !nv_wr;
  endproperty
  a_nvpulse: assert property (p_nvpulse) else $error("store pulse too long");
  property p_nvsrc;
    nv_wr |-> $past(cw) && $past(pwdata[CMD_NV_BIT]) && nv_wr_lba <= NATIVE_MAX_LBA;
  endproperty
  a_nvsrc: assert property (p_nvsrc) else $error("store without nonvolatile command");
  property p_cap;
    max_lba <= NATIVE_MAX_LBA;
  endproperty
  a_cap: assert property (p_cap) else $error("limit above native");
  property p_ident;
    rd && paddr == OFF_IDENT |-> prdata[ID_SETMAX_BIT];
  endproperty
  a_ident: assert property (p_ident) else $error("support bit clear");
  property p_idcap;
    rd && paddr == OFF_ID_CAP && $stable(max_lba) |-> prdata == max_lba[31:0] + 32'h1;
  endproperty
  a_idcap: assert property (p_idcap) else $error("identify capacity wrong");
  property p_maxrd;
    rd && paddr == OFF_MAX_LO && $stable(max_lba) |-> prdata == max_lba[31:0];
  endproperty
  a_maxrd: assert property (p_maxrd) else $error("limit readback wrong");
endmodule
bind mapc_ctrl mapc_chk u_mapc_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .nv_wr, .nv_wr_lba, .max_lba, .acc_valid, .acc_lba, .acc_done, .acc_deny);

// [tb/max_address_protected_area_ctrl_tb.sv]
/*
  Bench of mapc_ctrl with the store model.
  Assumes the checker file is compiled alongside.
*/
`timescale 1ns/1ps
module max_address_protected_area_ctrl_tb
  import mapc_pkg::*;
();
  localparam logic [47:0] LIM = 48'h0000_00BB_85FF;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic acc_valid = 1'b0, drive_reset = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [LBA_W-1:0] acc_lba = LBA_ZERO, nv_max_lba, nv_wr_lba, max_lba;
  logic pready, pslverr, nv_wr, acc_done, acc_deny, err_q;
  int err_total = 0, checks_done = 0;
  logic [48:0] rows [4] = '{{1'b0, LIM}, {1'b1, LIM + 48'h1}, {1'b0, LBA_ZERO}, {1'b1, NATIVE_MAX_LBA}};
  always #12.5 pclk = ~pclk;
  mapc_ctrl u_mapc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .drive_reset, .nv_max_lba, .nv_wr, .nv_wr_lba, .max_lba, .acc_valid, .acc_lba, .acc_done,
    .acc_deny);
  mapc_nv_store u_mapc_nv_store (.pclk, .nv_wr, .nv_wr_lba, .nv_max_lba);
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    chk("pready", 48'h1, {47'h0, pready});
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] sub, input logic nv);
    apb(1'b1, OFF_CMD, {15'h0, nv, sub, op});
  endtask
  task automatic setmax(input logic [47:0] lba, input logic nv);
    apb(1'b1, OFF_ARG_LO, lba[31:0]);
    apb(1'b1, OFF_ARG_HI, {16'h0, lba[47:32]});
    cmd(OP_SET_MAX, SUB_SET_MAX, nv);
  endtask
  task automatic st(input logic [3:0] e);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", {44'h0, e}, {44'h0, rd_q[4:1]});
  endtask
  task automatic native();
    cmd(OP_READ_NATIVE, 8'h00, 1'b0);
    apb(1'b0, OFF_RES_LO, 32'h0);
    chk("native", {16'h0, NATIVE_MAX_LBA[31:0]}, {16'h0, rd_q});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    chk("rst_max", NATIVE_MAX_LBA, max_lba);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    native();
    setmax(NATIVE_MAX_LBA, 1'b0);
    setmax(LIM, 1'b1);
    chk("max_nv", LIM, max_lba);
    // store takes the pulse one edge after the command
    @(posedge pclk);
    chk("stored", LIM, nv_max_lba);
    chk("store_lba", LIM, nv_wr_lba);
    apb(1'b0, OFF_ID_CAP, 32'h0);
    chk("id_cap", LIM[31:0] + 32'h1, {16'h0, rd_q});
    foreach (rows[i]) begin
      acc_valid <= 1'b1;
      acc_lba <= rows[i][47:0];
      @(posedge pclk);
      acc_valid <= 1'b0;
      @(posedge pclk);
      chk("acc_done", 48'h1, {47'h0, acc_done});
      chk("acc_deny", {47'h0, rows[i][48]}, {47'h0, acc_deny});
    end
    native();
    setmax(NATIVE_MAX_LBA, 1'b0);
    chk("max_vol", NATIVE_MAX_LBA, max_lba);
    chk("stored_vol", LIM, nv_max_lba);
    apb(1'b1, OFF_PWD, 32'h5A5A_0001);
    cmd(OP_SET_MAX, SUB_SET_PW, 1'b0);
    st(4'h8);
    apb(1'b0, OFF_IDENT, 32'h0);
    chk("ident", 48'h3, {46'h0, rd_q[24], rd_q[8]});
    cmd(OP_SET_MAX, SUB_LOCK, 1'b0);
    st(4'hA);
    setmax(LBA_ZERO, 1'b0);
    st(4'hB);
    chk("max_locked", NATIVE_MAX_LBA, max_lba);
    drive_reset <= 1'b1;
    repeat (4) @(posedge pclk);
    drive_reset <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("max_hrst", LIM, max_lba);
    st(4'hB);
    apb(1'b1, OFF_PWD, 32'h5A5A_0002);
    cmd(OP_SET_MAX, SUB_UNLOCK, 1'b0);
    st(4'hB);
    apb(1'b1, OFF_PWD, 32'h5A5A_0001);
    cmd(OP_SET_MAX, SUB_UNLOCK, 1'b0);
    st(4'h8);
    cmd(OP_SET_MAX, SUB_FREEZE, 1'b0);
    st(4'hC);
    cmd(OP_SET_MAX, SUB_UNLOCK, 1'b0);
    st(4'hD);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", 48'h0001_0000_0000, {15'h0, err_q, rd_q});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    st(4'h0);
    chk("max_por", LIM, max_lba);
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    give_verdict();
  end
endmodule
